//--- common/afms_consts.vh
/*
  Constants for the alert and fault mask and status block: command codes,
  field positions, reset values and writable-bit masks.
  Assumes inclusion by bare name from the block's design files.
*/
// Notes on behaviour
// - Alert mask bits 7,6 gate voltage, current alerts
// - Alert mask bit 3 gates comm/memory/logic alerts
// - Alert mask bit 2 gates monitor-voltage limit alerts
// - Alert mask bit 0 gates output power alerts
// - Fault mask bits 7,6 gate voltage, current faults
// - Fault mask bit 3 gates comm/memory/logic faults
// - Fault mask bit 0 gates output power faults
// - Regulation flag goes out as status word bit 3
// - Phase status bit 5 shows fourth phase enabled
// - Phase status bit 4 shows third phase enabled
// - Phase status bit 3 shows second phase enabled
// - Phase status bit 2 follows power-save indicator
`ifndef AFMS_CONSTS_VH
`define AFMS_CONSTS_VH

// Command codes
`define AFMS_CMD_ALERT_MASK 8'hf9
`define AFMS_CMD_FAULT_MASK 8'hfa
`define AFMS_CMD_GENERAL_STATUS 8'hfb
`define AFMS_CMD_PHASE_STATUS 8'hfc

// Reset values
`define AFMS_RST_ALERT_MASK 8'h00
`define AFMS_RST_FAULT_MASK 8'h00
`define AFMS_RST_GENERAL_STATUS 8'h00
`define AFMS_RST_PHASE_STATUS 8'h00

// Writable bits of the mask registers
`define AFMS_ALERT_MASK_WMASK 8'hcd
`define AFMS_FAULT_MASK_WMASK 8'hcd

// Mask register fields
`define AFMS_MSK_VOLT 7
`define AFMS_MSK_CURR 6
`define AFMS_MSK_COMM 3
`define AFMS_MSK_MON 2
`define AFMS_MSK_PWR 0

// General status fields
`define AFMS_GS_FAULT 7
`define AFMS_GS_ALERT 6
`define AFMS_GS_READY 4

// Phase status fields
`define AFMS_PS_PHASE4 5
`define AFMS_PS_PHASE3 4
`define AFMS_PS_PHASE2 3
`define AFMS_PS_POWER_SAVE 2

// Status word bit carrying the regulation flag
`define AFMS_SW_REGULATION 3

// Source group indices of the per-group flag vectors
`define AFMS_GRP_VOLT 4
`define AFMS_GRP_CURR 3
`define AFMS_GRP_COMM 2
`define AFMS_GRP_MON 1
`define AFMS_GRP_PWR 0
`define AFMS_NUM_GRP 5

`endif

//--- src/afms_sync.v
/*
  Two-flop synchroniser, one per bit, for levels arriving from pins.
  Assumes slowly changing levels; a pulse shorter than one clock may be lost.
*/
`timescale 1ns/1ps
`default_nettype none

module afms_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire clk_sys,
  input wire resetn,
  // Levels
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg stage1;
      reg stage2;
      // First stage feeds only the second
      always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
        end else begin
          stage1 <= async_in[i];
          stage2 <= stage1;
        end
      end
      assign sync_out[i] = stage2;
    end
  endgenerate

endmodule // afms_sync

`default_nettype wire

//--- src/afms_top.v
/*
  Alert and fault mask registers and the general and phase status bytes
  of the regulator's serial management port.
  Assumes a serial bus engine on clk_sys that decodes command codes and
  presents each byte access as a one-cycle request; source status bits
  come from logic on clk_sys, phase and ready levels arrive from pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "afms_consts.vh"

module afms_top (
  // Clock and reset
  input wire clk_sys,
  input wire resetn,
  // Command requests from the serial bus engine
  input wire cmd_valid,
  input wire cmd_write,
  input wire [7:0] cmd_code,
  input wire [7:0] cmd_wdata,
  // Command answers
  output reg rsp_valid,
  output reg rsp_hit,
  output reg [7:0] rsp_rdata,
  // Alert sources
  input wire [7:0] output_voltage_alert,
  input wire [7:0] output_current_alert,
  input wire [7:0] comm_memory_logic_alert,
  input wire [1:0] monitor_voltage_alert,
  input wire output_power_alert,
  // Fault sources
  input wire [7:0] output_voltage_fault,
  input wire [7:0] output_current_fault,
  input wire [7:0] comm_memory_logic_fault,
  input wire [1:0] monitor_voltage_fault,
  input wire output_power_fault,
  // Regulator levels from pins
  input wire regulator_ready_flag,
  input wire output_in_regulation_flag,
  input wire phase2_enable,
  input wire phase3_enable,
  input wire phase4_enable,
  input wire power_save_indicator,
  // Summaries
  output reg alert_active,
  output reg fault_active,
  output reg [4:0] alert_groups,
  output reg [4:0] fault_groups,
  output reg status_word_regulation,
  // Register images
  output reg [7:0] alert_mask,
  output reg [7:0] fault_mask,
  output reg [7:0] general_status,
  output reg [7:0] phase_status
);

  // Pin levels after synchronisation
  wire [5:0] pin_sync;
  wire ready_s;
  wire regulation_s;
  wire phase2_s;
  wire phase3_s;
  wire phase4_s;
  wire power_save_s;

  // Per-group raw and masked indications
  wire [4:0] alert_raw;
  wire [4:0] fault_raw;
  wire [4:0] alert_gate;
  wire [4:0] fault_gate;
  reg [4:0] next_alert_groups;
  reg [4:0] next_fault_groups;
  wire next_alert_active;
  wire next_fault_active;

  // Status byte next values
  reg [7:0] next_general_status;
  reg [7:0] next_phase_status;

  // Command decode
  reg [7:0] next_rdata;
  reg next_hit;
  wire write_alert_mask;
  wire write_fault_mask;

  afms_sync #(
    .WIDTH(6)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .async_in({power_save_indicator, phase4_enable, phase3_enable,
               phase2_enable, output_in_regulation_flag, regulator_ready_flag}),
    .sync_out(pin_sync)
  );

  assign ready_s = pin_sync[0];
  assign regulation_s = pin_sync[1];
  assign phase2_s = pin_sync[2];
  assign phase3_s = pin_sync[3];
  assign phase4_s = pin_sync[4];
  assign power_save_s = pin_sync[5];

  // Any bit of a group raises that group's indication
  assign alert_raw[`AFMS_GRP_VOLT] = |output_voltage_alert;
  assign alert_raw[`AFMS_GRP_CURR] = |output_current_alert;
  assign alert_raw[`AFMS_GRP_COMM] = |comm_memory_logic_alert;
  assign alert_raw[`AFMS_GRP_MON] = |monitor_voltage_alert;
  assign alert_raw[`AFMS_GRP_PWR] = output_power_alert;

  assign fault_raw[`AFMS_GRP_VOLT] = |output_voltage_fault;
  assign fault_raw[`AFMS_GRP_CURR] = |output_current_fault;
  assign fault_raw[`AFMS_GRP_COMM] = |comm_memory_logic_fault;
  assign fault_raw[`AFMS_GRP_MON] = |monitor_voltage_fault;
  assign fault_raw[`AFMS_GRP_PWR] = output_power_fault;

  // Mask bit of each group, per mask register
  assign alert_gate[`AFMS_GRP_VOLT] = alert_mask[`AFMS_MSK_VOLT];
  assign alert_gate[`AFMS_GRP_CURR] = alert_mask[`AFMS_MSK_CURR];
  assign alert_gate[`AFMS_GRP_COMM] = alert_mask[`AFMS_MSK_COMM];
  assign alert_gate[`AFMS_GRP_MON] = alert_mask[`AFMS_MSK_MON];
  assign alert_gate[`AFMS_GRP_PWR] = alert_mask[`AFMS_MSK_PWR];

  assign fault_gate[`AFMS_GRP_VOLT] = fault_mask[`AFMS_MSK_VOLT];
  assign fault_gate[`AFMS_GRP_CURR] = fault_mask[`AFMS_MSK_CURR];
  assign fault_gate[`AFMS_GRP_COMM] = fault_mask[`AFMS_MSK_COMM];
  assign fault_gate[`AFMS_GRP_MON] = fault_mask[`AFMS_MSK_MON];
  assign fault_gate[`AFMS_GRP_PWR] = fault_mask[`AFMS_MSK_PWR];

  always @* begin
    next_alert_groups = 5'h0;
    next_fault_groups = 5'h0;
    // Voltage, current, comm, monitor and power alerts
    next_alert_groups[`AFMS_GRP_VOLT] = alert_raw[`AFMS_GRP_VOLT] & ~alert_gate[`AFMS_GRP_VOLT];
    next_alert_groups[`AFMS_GRP_CURR] = alert_raw[`AFMS_GRP_CURR] & ~alert_gate[`AFMS_GRP_CURR];
    next_alert_groups[`AFMS_GRP_COMM] = alert_raw[`AFMS_GRP_COMM] & ~alert_gate[`AFMS_GRP_COMM];
    next_alert_groups[`AFMS_GRP_MON] = alert_raw[`AFMS_GRP_MON] & ~alert_gate[`AFMS_GRP_MON];
    next_alert_groups[`AFMS_GRP_PWR] = alert_raw[`AFMS_GRP_PWR] & ~alert_gate[`AFMS_GRP_PWR];
    // Voltage, current and comm faults
    next_fault_groups[`AFMS_GRP_VOLT] = fault_raw[`AFMS_GRP_VOLT] & ~fault_gate[`AFMS_GRP_VOLT];
    next_fault_groups[`AFMS_GRP_CURR] = fault_raw[`AFMS_GRP_CURR] & ~fault_gate[`AFMS_GRP_CURR];
    next_fault_groups[`AFMS_GRP_COMM] = fault_raw[`AFMS_GRP_COMM] & ~fault_gate[`AFMS_GRP_COMM];
    // Fault mask bit 2 also gates the monitor group, mirroring the alert side
    next_fault_groups[`AFMS_GRP_MON] = fault_raw[`AFMS_GRP_MON] & ~fault_gate[`AFMS_GRP_MON];
    next_fault_groups[`AFMS_GRP_PWR] = fault_raw[`AFMS_GRP_PWR] & ~fault_gate[`AFMS_GRP_PWR];
  end

  // Summaries come straight from the masked groups, so the summary bit
  // and the group vector always change on the same edge
  assign next_alert_active = |next_alert_groups;
  assign next_fault_active = |next_fault_groups;

  always @* begin
    next_general_status = 8'h00;
    next_general_status[`AFMS_GS_FAULT] = next_fault_active;
    next_general_status[`AFMS_GS_ALERT] = next_alert_active;
    next_general_status[`AFMS_GS_READY] = ready_s;
    // Bit 5 is obsolete and stays zero; regulation goes to the status word
  end

  always @* begin
    next_phase_status = 8'h00;
    next_phase_status[`AFMS_PS_PHASE4] = phase4_s;
    next_phase_status[`AFMS_PS_PHASE3] = phase3_s;
    next_phase_status[`AFMS_PS_PHASE2] = phase2_s;
    next_phase_status[`AFMS_PS_POWER_SAVE] = power_save_s;
  end

  // Mask writes
  assign write_alert_mask = cmd_valid & cmd_write & (cmd_code == `AFMS_CMD_ALERT_MASK);
  assign write_fault_mask = cmd_valid & cmd_write & (cmd_code == `AFMS_CMD_FAULT_MASK);

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      alert_mask <= `AFMS_RST_ALERT_MASK;
      fault_mask <= `AFMS_RST_FAULT_MASK;
    end else begin
      if (write_alert_mask) begin
        alert_mask <= cmd_wdata & `AFMS_ALERT_MASK_WMASK;
      end
      if (write_fault_mask) begin
        fault_mask <= cmd_wdata & `AFMS_FAULT_MASK_WMASK;
      end
    end
  end

  // Group and summary flops; live levels, nothing sticky
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      alert_groups <= 5'h0;
      fault_groups <= 5'h0;
      alert_active <= 1'b0;
      fault_active <= 1'b0;
    end else begin
      alert_groups <= next_alert_groups;
      fault_groups <= next_fault_groups;
      alert_active <= next_alert_active;
      fault_active <= next_fault_active;
    end
  end

  // Status byte images
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      general_status <= `AFMS_RST_GENERAL_STATUS;
      phase_status <= `AFMS_RST_PHASE_STATUS;
    end else begin
      general_status <= next_general_status;
      phase_status <= next_phase_status;
    end
  end

  // Regulation flag leaves the block for the status word, not this byte
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      status_word_regulation <= 1'b0;
    end else begin
      status_word_regulation <= regulation_s;
    end
  end

  // Read data and acceptance of each request.
  // Status bytes are read from their flops, so a read shows the value
  // that software could also see on the image outputs in that cycle.
  always @* begin
    next_rdata = 8'h00;
    next_hit = 1'b0;
    case (cmd_code)
      `AFMS_CMD_ALERT_MASK: begin
        next_hit = 1'b1;
        next_rdata = cmd_write ? 8'h00 : alert_mask;
      end
      `AFMS_CMD_FAULT_MASK: begin
        next_hit = 1'b1;
        next_rdata = cmd_write ? 8'h00 : fault_mask;
      end
      `AFMS_CMD_GENERAL_STATUS: begin
        // Writes to a read-only byte are refused
        next_hit = ~cmd_write;
        next_rdata = cmd_write ? 8'h00 : general_status;
      end
      `AFMS_CMD_PHASE_STATUS: begin
        next_hit = ~cmd_write;
        next_rdata = cmd_write ? 8'h00 : phase_status;
      end
      default: begin
        // Codes outside this block answer with a miss and zero data
        next_hit = 1'b0;
        next_rdata = 8'h00;
      end
    endcase
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rsp_valid <= 1'b0;
      rsp_hit <= 1'b0;
      rsp_rdata <= 8'h00;
    end else begin
      rsp_valid <= cmd_valid;
      if (cmd_valid) begin
        rsp_hit <= next_hit;
        rsp_rdata <= next_rdata;
      end else begin
        rsp_hit <= 1'b0;
        rsp_rdata <= 8'h00;
      end
    end
  end

endmodule // afms_top

`default_nettype wire

//--- bench/afms_checker_sva.sv
/*
  Concurrent checks on the mask and status block's ports.
  Assumes binding to afms_top, one clock domain on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
`include "afms_consts.vh"

module afms_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Requests
  input wire logic cmd_valid, cmd_write,
  input wire logic [7:0] cmd_code, cmd_wdata,
  // Sources
  input wire logic [7:0] output_voltage_alert, output_current_alert, comm_memory_logic_alert,
  input wire logic [7:0] output_voltage_fault, comm_memory_logic_fault,
  input wire logic [1:0] monitor_voltage_alert,
  input wire logic output_power_alert, output_power_fault,
  // Pin levels
  input wire logic regulator_ready_flag, output_in_regulation_flag,
  input wire logic phase2_enable, phase3_enable, phase4_enable, power_save_indicator,
  // Outputs
  input wire logic alert_active, fault_active, status_word_regulation,
  input wire logic [4:0] alert_groups, fault_groups,
  input wire logic [7:0] alert_mask, fault_mask, general_status, phase_status
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // Groups follow sources and the mask held one edge earlier
  property p_gate(logic g, logic m, logic s);
    $past(resetn) |-> g == ($past(s) && !$past(m));
  endproperty

  a_alert_output_voltage: assert property (p_gate(alert_groups[4], alert_mask[7], |output_voltage_alert))
    else $error("voltage alert group wrong");
  a_alert_output_current: assert property (p_gate(alert_groups[3], alert_mask[6], |output_current_alert))
    else $error("current alert group wrong");
  a_alert_cml: assert property (p_gate(alert_groups[2], alert_mask[3], |comm_memory_logic_alert))
    else $error("comm alert group wrong");
  a_alert_monitor_voltage: assert property (p_gate(alert_groups[1], alert_mask[2], |monitor_voltage_alert))
    else $error("monitor alert group wrong");
  a_alert_output_power: assert property (p_gate(alert_groups[0], alert_mask[0], output_power_alert))
    else $error("power alert group wrong");
  a_fault_output_voltage: assert property (p_gate(fault_groups[4], fault_mask[7], |output_voltage_fault))
    else $error("voltage fault group wrong");
  a_fault_cml: assert property (p_gate(fault_groups[2], fault_mask[3], |comm_memory_logic_fault))
    else $error("comm fault group wrong");
  a_fault_output_power: assert property (p_gate(fault_groups[0], fault_mask[0], output_power_fault))
    else $error("power fault group wrong");
  a_summary_bits: assert property ({general_status[7:6], fault_active, alert_active} ==
    {|fault_groups, |alert_groups, |fault_groups, |alert_groups}) else $error("summary bits wrong");
  a_reserved_zero: assert property (((alert_mask | fault_mask) & ~`AFMS_ALERT_MASK_WMASK) == 8'h00
    && {general_status[5], general_status[3:0], phase_status[7:6], phase_status[1:0]} == 9'h000)
    else $error("reserved bit set");
  a_phase_follow: assert property ($past(resetn, 3) |-> phase_status[5:2] ==
    $past({phase4_enable, phase3_enable, phase2_enable, power_save_indicator}, 3)) else $error("phase bits wrong");
  a_ready_follow: assert property ($past(resetn, 3) |-> {general_status[4], status_word_regulation} ==
    $past({regulator_ready_flag, output_in_regulation_flag}, 3)) else $error("ready or regulation wrong");
  a_mask_write: assert property (cmd_valid && cmd_write && cmd_code == 8'hfa |=>
    fault_mask == ($past(cmd_wdata) & `AFMS_FAULT_MASK_WMASK)) else $error("fault mask write wrong");

  c_masked_alert: cover property (alert_mask[7] && |output_voltage_alert);
  c_phase_all: cover property (phase_status[5:2] == 4'hf);
  c_fault_up: cover property ($rose(fault_active));
endmodule // afms_checker

bind afms_top afms_checker chk_u (.*);

`default_nettype wire

//--- bench/afms_host.sv
/*
  Management bus host model: one command per call.
  Assumes the answer is registered on the taking edge and read at the next falling edge.
*/
`timescale 1ns/1ps
`default_nettype none

module afms_host (
  // Clock
  input wire logic clk_sys,
  // Requests
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [7:0] cmd_wdata,
  // Answers
  input wire logic rsp_valid,
  input wire logic rsp_hit,
  input wire logic [7:0] rsp_rdata
);
  logic got_valid, got_hit;
  logic [7:0] got_data;

  initial {cmd_valid, cmd_write, cmd_code, cmd_wdata} = 18'h0_0000;

  // Idle qualifiers flip so a stale value never passes for a live one
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] data);
    @(negedge clk_sys);
    {cmd_valid, cmd_write, cmd_code, cmd_wdata} = {1'b1, wr, code, data};
    @(negedge clk_sys);
    {got_valid, got_hit, got_data} = {rsp_valid, rsp_hit, rsp_rdata};
    {cmd_valid, cmd_write, cmd_code, cmd_wdata} = {1'b0, ~wr, ~code, ~data};
  endtask
endmodule // afms_host

`default_nettype wire

//--- bench/alert_fault_mask_status_test.sv
/*
  Self-checking bench for the mask and status block.
  Assumes the host model as bus master; inputs change on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
`include "afms_consts.vh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end

module alert_fault_mask_status_test;
  logic clk_sys, resetn;
  logic [7:0] output_voltage_alert, output_current_alert, comm_memory_logic_alert;
  logic [7:0] output_voltage_fault, output_current_fault, comm_memory_logic_fault;
  logic [1:0] monitor_voltage_alert, monitor_voltage_fault;
  logic output_power_alert, output_power_fault, regulator_ready_flag, output_in_regulation_flag;
  logic phase2_enable, phase3_enable, phase4_enable, power_save_indicator;
  wire cmd_valid, cmd_write, rsp_valid, rsp_hit, alert_active, fault_active, status_word_regulation;
  wire [7:0] cmd_code, cmd_wdata, rsp_rdata, alert_mask, fault_mask, general_status, phase_status;
  wire [4:0] alert_groups, fault_groups;
  int n_errors = 0;
  int num_checks = 0;
  int i;
  logic [7:0] am, fm;
  logic [4:0] s, ea, ef;
  // Rows: alert mask, fault mask, active groups, expected alert and fault groups
  logic [30:0] rows [8] = '{{8'h00, 8'h00, 5'h1f, 5'h1f, 5'h1f}, {8'h80, 8'h40, 5'h1f, 5'h0f, 5'h17},
    {8'h40, 8'h80, 5'h18, 5'h10, 5'h08}, {8'h08, 8'h04, 5'h04, 5'h00, 5'h04},
    {8'h04, 8'h08, 5'h06, 5'h04, 5'h02}, {8'h01, 8'h01, 5'h01, 5'h00, 5'h00},
    {8'h00, 8'hcd, 5'h02, 5'h02, 5'h00}, {8'hff, 8'hff, 5'h1f, 5'h00, 5'h00}};

  afms_top dut_u (.*);
  afms_host host_u (.*);

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  initial begin
    #200000;
    n_errors++;
    tally_and_finish();
  end

  task automatic tally_and_finish();
    if (n_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Walking bit position shows bits 0-2 of voltage and current, bits 0, 1, 3, 4 of comm and both monitor bits set them; bit 7 only with all groups masked
  task automatic drive_src(input logic [4:0] g, input int k);
    logic [7:0] b;
    b = 8'h01 << (k % 8);
    {output_voltage_alert, output_voltage_fault} = g[4] ? {b, b} : 16'h0000;
    {output_current_alert, output_current_fault} = g[3] ? {b, b} : 16'h0000;
    {comm_memory_logic_alert, comm_memory_logic_fault} = g[2] ? {b, b} : 16'h0000;
    {monitor_voltage_alert, monitor_voltage_fault} = g[1] ? {2{2'h1 << k[0]}} : 4'h0;
    {output_power_alert, output_power_fault} = {2{g[0]}};
  endtask

  initial begin
    resetn = 1'b0;
    {regulator_ready_flag, output_in_regulation_flag, power_save_indicator} = 3'h0;
    {phase2_enable, phase3_enable, phase4_enable} = 3'h0;
    drive_src(5'h00, 0);
    repeat (4) @(negedge clk_sys);
    resetn = 1'b1;
    for (i = 0; i < 4; i++) begin
      host_u.xfer(1'b0, 8'(8'hf9 + i), 8'h00);
      `CHK("reset value", 8'h00, host_u.got_data)
    end
    foreach (rows[r]) begin
      {am, fm, s, ea, ef} = rows[r];
      host_u.xfer(1'b1, `AFMS_CMD_ALERT_MASK, am);
      `CHK("write answer", 10'h300, ({host_u.got_valid, host_u.got_hit, host_u.got_data}))
      host_u.xfer(1'b1, `AFMS_CMD_FAULT_MASK, fm);
      drive_src(s, r);
      repeat (2) @(negedge clk_sys);
      `CHK("alert_groups", ea, alert_groups)
      `CHK("fault_groups", ef, fault_groups)
      `CHK("summaries", ({|ea, |ef}), ({alert_active, fault_active}))
      host_u.xfer(1'b0, `AFMS_CMD_GENERAL_STATUS, 8'h00);
      `CHK("general_status", ({|ef, |ea, 6'h00}), host_u.got_data)
      host_u.xfer(1'b0, `AFMS_CMD_ALERT_MASK, 8'h00);
      `CHK("alert_mask", (am & `AFMS_ALERT_MASK_WMASK), host_u.got_data)
    end
    for (i = 0; i < 16; i += 5) begin
      {phase4_enable, phase3_enable, phase2_enable, power_save_indicator} = i[3:0];
      {regulator_ready_flag, output_in_regulation_flag} = i[1:0];
      repeat (4) @(negedge clk_sys);
      host_u.xfer(1'b0, `AFMS_CMD_PHASE_STATUS, 8'h00);
      `CHK("phase_status", ({2'b00, i[3:0], 2'b00}), host_u.got_data)
      `CHK("ready", i[1:0], ({general_status[4], status_word_regulation}))
    end
    // Refused: write to a read-only byte, then an unmapped read
    host_u.xfer(1'b1, `AFMS_CMD_PHASE_STATUS, 8'h00);
    `CHK("ro write", 10'h200, ({host_u.got_valid, host_u.got_hit, host_u.got_data}))
    `CHK("ro kept", 8'h3c, phase_status)
    host_u.xfer(1'b0, 8'hf8, 8'h00);
    `CHK("unmapped", 10'h200, ({host_u.got_valid, host_u.got_hit, host_u.got_data}))
    @(negedge clk_sys) resetn = 1'b0;
    repeat (4) @(negedge clk_sys);
    `CHK("mask in reset", 16'h0000, ({alert_mask, fault_mask}))
    resetn = 1'b1;
    tally_and_finish();
  end
endmodule // alert_fault_mask_status_test

`default_nettype wire
